// File: design/pecr_ahb_slave.sv
// Purpose: AHB-Lite slave front end with one wait state per access
// Assumes: Single word transfers, one master
// Notes:   Read data and ready come from flip-flops
`timescale 1ns/1ps
module pecr_ahb_slave
	import pecr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	pecr_reg_if.slave        rif
);

	pecr_slv_state_t state_q;
	logic [11:0]     addr_q;
	logic            wr_q;

	// ------------------------------------------------------------------
	// Access sequencing
	// ------------------------------------------------------------------
	// The wait state lets write data be used in the cycle it arrives and
	// lets read data leave from a flop, at the cost of one cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q   <= SLV_IDLE;
			addr_q    <= 12'h000;
			wr_q      <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= UNMAPPED_READ;
		end
		else
		begin
			case (state_q)
				SLV_IDLE:
				begin
					if (hsel && hready && htrans[1])
					begin
						state_q   <= SLV_ACCESS;
						addr_q    <= {haddr[11:2], 2'b00};
						// Narrow writes are ignored
						wr_q      <= hwrite && (hsize == HSIZE_WORD);
						hreadyout <= 1'b0;
					end
				end
				SLV_ACCESS:
				begin
					state_q   <= SLV_IDLE;
					hreadyout <= 1'b1;
					hrdata    <= wr_q ? UNMAPPED_READ : rif.rdata;
				end
				default:
				begin
					state_q   <= SLV_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= HRESP_OKAY;
		else
			hresp <= HRESP_OKAY;
	end

	assign rif.req   = (state_q == SLV_ACCESS);
	assign rif.wr    = wr_q;
	assign rif.addr  = addr_q;
	assign rif.wdata = hwdata;

endmodule : pecr_ahb_slave

// File: design/pecr_top.sv
// Purpose: Extended capability register bank of a switch port
// Assumes: Error capture and lock come from neighbouring logic
// Notes:   Logged header and serial number sit in the sticky domain
//
// Summary of operation
// RL1 - Second header doubleword of first uncorrectable error; sticky, zero.
// RL2 - Third header doubleword of first uncorrectable error, read only.
// RL3 - Fourth header doubleword of first uncorrectable error, read only.
// RL4 - Log only the first error; hold until software clears its status.
// RL5 - Serial number header identifier reads 0x3.
// RL6 - Both capability headers report version 0x1 in bits 19:16.
// RL7 - Lockable next pointer in bits 31:20 of each header, reset zero.
// RL8 - Lower unique identifier word, lockable write, sticky, reset zero.
// RL9 - Upper unique identifier word, lockable write, sticky, reset zero.
// RL10 - Lockable fields accept writes only while the write lock is released.
// RL11 - Virtual channel header identifier reads 0x2.
// RL12 - Extra channel count in bits 2:0 reads zero.
// RL13 - Low priority channel count in bits 6:4 reads zero.
// RL14 - Arbitration time base in bits 9:8 reads zero.
// RL15 - Entry size reads 0x2 on upstream port, 0x0 on downstream.
// RL16 - Entry size codes: 0 one bit, 1 two, 2 four, 3 eight.
// RL17 - Reserved bits 3, 7, 31:12 of port capability read zero.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module pecr_top
	import pecr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        sticky_resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        err_log_valid,
	input  wire logic [31:0] err_hdr_dw2,
	input  wire logic [31:0] err_hdr_dw3,
	input  wire logic [31:0] err_hdr_dw4,
	input  wire logic        err_status_clear,
	input  wire logic        write_lock,
	input  wire logic        upstream_port,
	output logic [63:0]      unique_id,
	output logic             log_held
);

	// ------------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------------
	pecr_reg_if rif ();

	pecr_ahb_slave u_slave
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rif       (rif.slave)
	);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [31:0] hdr_log_q [3];
	logic        log_held_q;
	logic [11:0] unique_id_field_next_ptr_q;
	logic [11:0] vc_next_ptr_q;
	logic [31:0] unique_id_field_low_q;
	logic [31:0] unique_id_field_high_q;
	logic        lock_ok;
	logic        capture;
	logic [31:0] rdata;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] cap_header
	(
		input logic [15:0] id,
		input logic [11:0] next_ptr
	);
		cap_header = {next_ptr, CAP_VERSION, id}; // [RL6]
	endfunction : cap_header

	function automatic logic write_hit
	(
		input logic        req,
		input logic        wr,
		input logic [11:0] addr,
		input logic [11:0] offset
	);
		write_hit = req && wr && (addr == offset);
	endfunction : write_hit

	function automatic logic [1:0] entry_size
	(
		input logic upstream
	);
		// Upstream uses a table of four bit entries
		entry_size = upstream ? ENTRY_SIZE_4BIT
		                      : ENTRY_SIZE_1BIT; // [RL15] [RL16]
	endfunction : entry_size

	// ------------------------------------------------------------------
	// Header log capture
	// ------------------------------------------------------------------
	// A new error is taken only while nothing is held; an error arriving in the
	// same cycle as the status clear is not taken, and the older log stays held.
	assign capture = err_log_valid && !log_held_q; // [RL4]

	always_ff @(posedge hclk or negedge sticky_resetn)
	begin
		if (!sticky_resetn)
		begin
			hdr_log_q[0] <= HDR_LOG_RESET; // [RL1]
			hdr_log_q[1] <= HDR_LOG_RESET;
			hdr_log_q[2] <= HDR_LOG_RESET;
		end
		else if (capture)
		begin
			hdr_log_q[0] <= err_hdr_dw2; // [RL1]
			hdr_log_q[1] <= err_hdr_dw3; // [RL2]
			hdr_log_q[2] <= err_hdr_dw4; // [RL3]
		end
	end

	// An error arriving with the clear keeps the log held: the set wins.
	always_ff @(posedge hclk or negedge sticky_resetn)
	begin
		if (!sticky_resetn)
			log_held_q <= 1'b0;
		else if (err_log_valid)
			log_held_q <= 1'b1; // [RL4]
		else if (err_status_clear)
			log_held_q <= 1'b0; // [RL4]
	end

	assign log_held = log_held_q;

	// ------------------------------------------------------------------
	// Lockable fields
	// ------------------------------------------------------------------
	// Writes under lock are dropped silently; the bus still answers OKAY.
	assign lock_ok = !write_lock; // [RL10]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			unique_id_field_next_ptr_q <= NEXT_PTR_RESET; // [RL7]
		else if (lock_ok &&
		         write_hit(rif.req, rif.wr, rif.addr, OFF_UNIQUE_ID_FIELD_CAP_HDR))
			unique_id_field_next_ptr_q <= rif.wdata[31:20]; // [RL7] [RL10]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			vc_next_ptr_q <= NEXT_PTR_RESET; // [RL7]
		else if (lock_ok &&
		         write_hit(rif.req, rif.wr, rif.addr, OFF_VC_CAP_HDR))
			vc_next_ptr_q <= rif.wdata[31:20]; // [RL7] [RL10]
	end

	// Serial number survives a normal reset so it need only be loaded once.
	always_ff @(posedge hclk or negedge sticky_resetn)
	begin
		if (!sticky_resetn)
			unique_id_field_low_q <= UNIQUE_ID_FIELD_RESET; // [RL8]
		else if (lock_ok &&
		         write_hit(rif.req, rif.wr, rif.addr, OFF_UNIQUE_ID_FIELD_LOW))
			unique_id_field_low_q <= rif.wdata; // [RL8] [RL10]
	end

	always_ff @(posedge hclk or negedge sticky_resetn)
	begin
		if (!sticky_resetn)
			unique_id_field_high_q <= UNIQUE_ID_FIELD_RESET; // [RL9]
		else if (lock_ok &&
		         write_hit(rif.req, rif.wr, rif.addr, OFF_UNIQUE_ID_FIELD_HIGH))
			unique_id_field_high_q <= rif.wdata; // [RL9] [RL10]
	end

	assign unique_id = {unique_id_field_high_q, unique_id_field_low_q};

	// ------------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------------
	// The strap is read live; the slave flops the result, so a strap that
	// moves mid-access cannot tear the returned word.
	always_comb
	begin
		rdata = UNMAPPED_READ;
		case (rif.addr)
			OFF_HDR_LOG_DW2:
				rdata = hdr_log_q[0]; // [RL1]
			OFF_HDR_LOG_DW3:
				rdata = hdr_log_q[1]; // [RL2]
			OFF_HDR_LOG_DW4:
				rdata = hdr_log_q[2]; // [RL3]
			OFF_UNIQUE_ID_FIELD_CAP_HDR:
				rdata = cap_header(CAP_ID_SERIAL,
				                   unique_id_field_next_ptr_q); // [RL5] [RL6] [RL7]
			OFF_UNIQUE_ID_FIELD_LOW:
				rdata = unique_id_field_low_q; // [RL8]
			OFF_UNIQUE_ID_FIELD_HIGH:
				rdata = unique_id_field_high_q; // [RL9]
			OFF_VC_CAP_HDR:
				rdata = cap_header(CAP_ID_VC,
				                   vc_next_ptr_q); // [RL11] [RL6] [RL7]
			OFF_PORT_VC_CAP1:
			begin
				rdata        = 32'h0000_0000; // [RL17]
				rdata[2:0]   = EXTRA_CHAN_COUNT; // [RL12]
				rdata[6:4]   = LOW_PRIO_COUNT; // [RL13]
				rdata[9:8]   = ARB_TIME_BASE; // [RL14]
				rdata[11:10] = entry_size(upstream_port); // [RL15]
			end
			default:
				rdata = UNMAPPED_READ;
		endcase
	end

	assign rif.rdata = rdata;

endmodule : pecr_top

// File: inc/pecr_pkg.sv
// Purpose: Shared constants for the extended capability register bank
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Offsets are byte addresses within the configuration space
package pecr_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] OFF_HDR_LOG_DW2   = 12'h120;
	localparam logic [11:0] OFF_HDR_LOG_DW3   = 12'h124;
	localparam logic [11:0] OFF_HDR_LOG_DW4   = 12'h128;
	localparam logic [11:0] OFF_UNIQUE_ID_FIELD_CAP_HDR  = 12'h180;
	localparam logic [11:0] OFF_UNIQUE_ID_FIELD_LOW      = 12'h184;
	localparam logic [11:0] OFF_UNIQUE_ID_FIELD_HIGH     = 12'h188;
	localparam logic [11:0] OFF_VC_CAP_HDR    = 12'h200;
	localparam logic [11:0] OFF_PORT_VC_CAP1  = 12'h204;

	// ------------------------------------------------------------------
	// Capability header fields
	// ------------------------------------------------------------------
	localparam logic [15:0] CAP_ID_SERIAL     = 16'h0003;
	localparam logic [15:0] CAP_ID_VC         = 16'h0002;
	localparam logic [3:0]  CAP_VERSION       = 4'h1;
	localparam logic [11:0] NEXT_PTR_RESET    = 12'h000;

	// ------------------------------------------------------------------
	// Port channel capability one fields
	// ------------------------------------------------------------------
	localparam logic [2:0]  EXTRA_CHAN_COUNT  = 3'h0;
	localparam logic [2:0]  LOW_PRIO_COUNT    = 3'h0;
	localparam logic [1:0]  ARB_TIME_BASE     = 2'h0;
	localparam logic [1:0]  ENTRY_SIZE_1BIT   = 2'h0;
	localparam logic [1:0]  ENTRY_SIZE_2BIT   = 2'h1;
	localparam logic [1:0]  ENTRY_SIZE_4BIT   = 2'h2;
	localparam logic [1:0]  ENTRY_SIZE_8BIT   = 2'h3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] HDR_LOG_RESET     = 32'h0000_0000;
	localparam logic [31:0] UNIQUE_ID_FIELD_RESET        = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------------
	localparam logic [2:0]  HSIZE_WORD        = 3'h2;
	localparam logic        HRESP_OKAY        = 1'h0;

	typedef enum logic {SLV_IDLE, SLV_ACCESS} pecr_slv_state_t;

endpackage : pecr_pkg

// File: inc/pecr_reg_if.sv
// Purpose: Register access strobe between bus slave and register bank
// Assumes: One access at a time, strobe lasts one cycle
// Notes:   Read data returns combinationally in the same cycle
`timescale 1ns/1ps
interface pecr_reg_if;
	logic        req;
	logic        wr;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport slave
	(
		output req,
		output wr,
		output addr,
		output wdata,
		input  rdata
	);

	modport regs
	(
		input  req,
		input  wr,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface : pecr_reg_if

// File: verif/pecr_properties.sv
// Purpose: Port level checks of the capability register bank
// Assumes: hready is fed back from hreadyout
// Notes:   Both resets quiet every check
`timescale 1ns/1ps
module pecr_checker
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        sticky_resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        err_log_valid,
	input wire logic        err_status_clear,
	input wire logic        write_lock,
	input wire logic        upstream_port,
	input wire logic [63:0] unique_id,
	input wire logic        log_held
);
	logic take;

	assign take = hsel && hready && htrans[1] && hreadyout;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || !sticky_resetn);

	// ------------------------------------------------------------------
	// Bus timing
	// ------------------------------------------------------------------
	a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("access not answered after one wait");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rdata_held: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data moved outside an access");

	// ------------------------------------------------------------------
	// Read values, seen one edge after the wait cycle
	// ------------------------------------------------------------------
	a_serial_hdr: assert property (
		take && !hwrite && haddr[11:0] == 12'h180
		|=> ##1 hrdata[19:0] == 20'h10003)
		else $error("serial header id or version wrong");
	a_chan_hdr: assert property (
		take && !hwrite && haddr[11:0] == 12'h200
		|=> ##1 hrdata[19:0] == 20'h10002)
		else $error("channel header id or version wrong");
	a_port_cap: assert property (
		take && !hwrite && haddr[11:0] == 12'h204
		|=> ##1 hrdata == {20'h0, upstream_port, 11'h0})
		else $error("port capability value wrong");

	// ------------------------------------------------------------------
	// Serial number and error log
	// ------------------------------------------------------------------
	a_id_bus_only: assert property (hreadyout |=> $stable(unique_id))
		else $error("serial number moved outside a write");
	a_id_locked: assert property (write_lock |=> $stable(unique_id))
		else $error("serial number written while locked");
	a_log_capture: assert property (err_log_valid |=> log_held)
		else $error("error not logged");
	a_log_clear: assert property (
		log_held && err_status_clear && !err_log_valid |=> !log_held)
		else $error("log not released");
endmodule : pecr_checker

bind pecr_top pecr_checker chk_u (.hclk(hclk), .hresetn(hresetn),
	.sticky_resetn(sticky_resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.err_log_valid(err_log_valid), .err_status_clear(err_status_clear),
	.write_lock(write_lock), .upstream_port(upstream_port),
	.unique_id(unique_id), .log_held(log_held));

// File: verif/tb.sv
// Purpose: Self-checking bench of the capability register bank
// Assumes: One bus master, single transfers, all word sized but one byte write
// Notes:   Both resets start low together
`timescale 1ns/1ps
module tb
	import pecr_pkg::*;
;
	logic        hclk, hresetn, sticky_resetn, hsel, hwrite, hready;
	logic        hreadyout, hresp, log_held, err_log_valid;
	logic        err_status_clear, write_lock, upstream_port;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, err_hdr_dw2, err_hdr_dw3;
	logic [31:0] err_hdr_dw4;
	logic [63:0] unique_id;
	logic [31:0] cap1;
	int          errors, n_tests;

	assign hready = hreadyout;

	pecr_top dut_u (.hclk(hclk), .hresetn(hresetn),
		.sticky_resetn(sticky_resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .err_log_valid(err_log_valid),
		.err_hdr_dw2(err_hdr_dw2), .err_hdr_dw3(err_hdr_dw3),
		.err_hdr_dw4(err_hdr_dw4), .err_status_clear(err_status_clear),
		.write_lock(write_lock), .upstream_port(upstream_port),
		.unique_id(unique_id), .log_held(log_held));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Bounded so a stuck slave ends the run instead of hanging it
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				errors++;
				$display("unexpected hready: expected 1 seen 0");
				final_report();
			end
			@(posedge hclk);
		end
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, a};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr32

	task automatic rd_chk(input string name, input logic [11:0] a,
		input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(name, {32'h0, r}, {32'h0, exp});
	endtask : rd_chk

	task automatic raise_err(input logic [31:0] w);
		@(posedge hclk);
		err_log_valid <= 1'b1;
		err_hdr_dw2 <= w;
		err_hdr_dw3 <= ~w;
		err_hdr_dw4 <= w ^ 32'h5a5a_5a5a;
		@(posedge hclk);
		err_log_valid <= 1'b0;
	endtask : raise_err

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values;
		rd_chk("log_dw2", OFF_HDR_LOG_DW2, HDR_LOG_RESET);
		rd_chk("log_dw3", OFF_HDR_LOG_DW3, HDR_LOG_RESET);
		rd_chk("log_dw4", OFF_HDR_LOG_DW4, HDR_LOG_RESET);
		rd_chk("id_low", OFF_UNIQUE_ID_FIELD_LOW, UNIQUE_ID_FIELD_RESET);
		rd_chk("id_high", OFF_UNIQUE_ID_FIELD_HIGH, UNIQUE_ID_FIELD_RESET);
		rd_chk("sn_hdr", OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'h0001_0003);
		rd_chk("vc_hdr", OFF_VC_CAP_HDR, 32'h0001_0002);
		rd_chk("cap1_down", OFF_PORT_VC_CAP1, 32'h0);
		rd_chk("unmapped", 12'h300, UNMAPPED_READ);
	endtask : t_reset_values

	task automatic t_port_cap;
		cap1 = {20'h0, ENTRY_SIZE_4BIT, 10'h0};
		upstream_port <= 1'b1;
		rd_chk("cap1_up", OFF_PORT_VC_CAP1, cap1);
		wr32(OFF_PORT_VC_CAP1, 32'hffff_ffff);
		rd_chk("cap1_rsvd", OFF_PORT_VC_CAP1, cap1);
		upstream_port <= 1'b0;
		rd_chk("cap1_down2", OFF_PORT_VC_CAP1, 32'h0);
	endtask : t_port_cap

	task automatic t_serial;
		wr32(OFF_UNIQUE_ID_FIELD_LOW, 32'h1234_5678);
		wr32(OFF_UNIQUE_ID_FIELD_HIGH, 32'h9abc_def0);
		rd_chk("id_low_wr", OFF_UNIQUE_ID_FIELD_LOW, 32'h1234_5678);
		rd_chk("id_high_wr", OFF_UNIQUE_ID_FIELD_HIGH, 32'h9abc_def0);
		check("unique_id", unique_id, 64'h9abc_def0_1234_5678);
		// A byte-sized write must leave the word untouched
		hsize <= 3'h0;
		wr32(OFF_UNIQUE_ID_FIELD_LOW, 32'hdead_beef);
		hsize <= HSIZE_WORD;
		rd_chk("id_narrow", OFF_UNIQUE_ID_FIELD_LOW, 32'h1234_5678);
		write_lock <= 1'b1;
		wr32(OFF_UNIQUE_ID_FIELD_LOW, 32'h0);
		check("hresp", {63'h0, hresp}, {63'h0, HRESP_OKAY});
		wr32(OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'hfff0_0000);
		rd_chk("id_locked", OFF_UNIQUE_ID_FIELD_LOW, 32'h1234_5678);
		rd_chk("ptr_locked", OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'h0001_0003);
		write_lock <= 1'b0;
		wr32(OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'hfff0_0000);
		wr32(OFF_VC_CAP_HDR, 32'h123f_ffff);
		rd_chk("sn_ptr", OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'hfff1_0003);
		rd_chk("vc_ptr", OFF_VC_CAP_HDR, 32'h1231_0002);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ptr_reset", OFF_UNIQUE_ID_FIELD_CAP_HDR, 32'h0001_0003);
		check("id_sticky", unique_id, 64'h9abc_def0_1234_5678);
	endtask : t_serial

	task automatic t_log;
		raise_err(32'h0bad_c0de);
		raise_err(32'h1111_2222);
		@(posedge hclk);
		check("log_held", {63'h0, log_held}, 64'h1);
		wr32(OFF_HDR_LOG_DW2, 32'h0);
		rd_chk("log2", OFF_HDR_LOG_DW2, 32'h0bad_c0de);
		rd_chk("log3", OFF_HDR_LOG_DW3, ~32'h0bad_c0de);
		rd_chk("log4", OFF_HDR_LOG_DW4, 32'h51f7_9a84);
		@(posedge hclk);
		err_status_clear <= 1'b1;
		@(posedge hclk);
		err_status_clear <= 1'b0;
		@(posedge hclk);
		check("log_free", {63'h0, log_held}, 64'h0);
		raise_err(32'h3333_4444);
		rd_chk("log2_new", OFF_HDR_LOG_DW2, 32'h3333_4444);
		// Error and clear together: the error wins and the log stays held
		@(posedge hclk);
		err_status_clear <= 1'b1;
		err_log_valid <= 1'b1;
		err_hdr_dw2 <= 32'h5555_6666;
		@(posedge hclk);
		err_status_clear <= 1'b0;
		err_log_valid <= 1'b0;
		@(posedge hclk);
		check("log_set_wins", {63'h0, log_held}, 64'h1);
		rd_chk("log2_kept", OFF_HDR_LOG_DW2, 32'h3333_4444);
	endtask : t_log

	initial
	begin
		errors = 0;
		n_tests = 0;
		hresetn = 1'b0;
		sticky_resetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		haddr = 32'h0;
		hwdata = 32'h0;
		err_log_valid = 1'b0;
		err_hdr_dw2 = 32'h0;
		err_hdr_dw3 = 32'h0;
		err_hdr_dw4 = 32'h0;
		err_status_clear = 1'b0;
		write_lock = 1'b0;
		upstream_port = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		sticky_resetn <= 1'b1;
		t_reset_values();
		t_port_cap();
		t_serial();
		t_log();
		final_report();
	end
endmodule : tb
